// *** rtl/spf_cfg.svh ***
// field positions, codes and sizes of the sink object formatter
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

`define SPF_FLD_W        10
`define SPF_TYPE_LSB     30
`define SPF_VMAX_LSB     20
`define SPF_VMIN_LSB     10
`define SPF_OP_LSB       10
`define SPF_LIM_LSB      0
`define SPF_POS_LSB      28
`define SPF_GB_BIT       27
`define SPF_MM_BIT       26
`define SPF_USB_BIT      25
`define SPF_NOSUSP_BIT   24
`define SPF_UNCHK_BIT    23
`define SPF_TYPE_FIXED   2'h0
`define SPF_TYPE_BATT    2'h1
`define SPF_TYPE_VAR     2'h2
`define SPF_POS_RESV     3'h0
`define SPF_CAP_DEPTH    7
`define SPF_VOLT_STEP_MV 50
`define SPF_CUR_STEP_MA  10
`define SPF_PWR_STEP_MW  250
`define SPF_ERR_W        4
`define SPF_ERR_POS      0
`define SPF_ERR_OP       1
`define SPF_ERR_GB       2
`define SPF_ERR_TYPE     3

`endif

// *** rtl/spf_pkg.sv ***
// types of the sink object formatter
package spf_pkg;
	typedef enum logic [1:0] {
		SPF_IDLE,
		SPF_READ,
		SPF_CHECK
	} spf_state_t;

	typedef logic [31:0] spf_word_t;
	typedef logic [2:0]  spf_pos_t;
endpackage

// *** rtl/spf_cap_if.sv ***
// carrier between formatter and offered capability store
`timescale 1ns/100ps
interface spf_cap_if;
	logic               wr_en;
	spf_pkg::spf_pos_t  wr_addr;
	spf_pkg::spf_word_t wr_data;
	logic               rd_en;
	spf_pkg::spf_pos_t  rd_addr;
	spf_pkg::spf_word_t rd_data;

	modport ctl (output wr_en, output wr_addr, output wr_data,
		output rd_en, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_en, input rd_addr, output rd_data);
endinterface

// *** rtl/spf_cap_mem.sv ***
// store of the last offered source capability objects
`timescale 1ns/100ps
`include "spf_cfg.svh"
module spf_cap_mem #(
	parameter int DEPTH = `SPF_CAP_DEPTH
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	spf_cap_if.mem    bus
);
	spf_pkg::spf_word_t mem [DEPTH];
	spf_pkg::spf_word_t rd_q;

	// array kept without reset: contents only count below the stored total
	always_ff @(posedge clk_sys) begin
		if (bus.wr_en) begin
			mem[bus.wr_addr] <= bus.wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 32'h00000000;
		end else if (bus.rd_en) begin
			rd_q <= mem[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_q;
endmodule

// *** rtl/spf_rdo_check.sv ***
// validity checks of a request against the referenced offered object
`timescale 1ns/100ps
`include "spf_cfg.svh"
module spf_rdo_check #(
	parameter int FW = `SPF_FLD_W
) (
	input  wire spf_pkg::spf_word_t pdo,
	input  wire logic [FW-1:0]      op,
	input  wire logic [FW-1:0]      lim,
	input  wire logic               giveback,
	output logic                    is_batt,
	output logic                    type_bad,
	output logic                    op_over,
	output logic                    lim_over,
	output logic                    gb_bad
);
	logic [1:0]    kind;
	logic [FW-1:0] offer;

	always_comb begin
		kind  = pdo[`SPF_TYPE_LSB +: 2];
		offer = pdo[`SPF_LIM_LSB +: FW];
		is_batt  = (kind == `SPF_TYPE_BATT);
		type_bad = (kind != `SPF_TYPE_FIXED) && (kind != `SPF_TYPE_VAR) && !is_batt;
		op_over  = (op > offer);
		lim_over = !giveback && (lim > offer);
		gb_bad   = giveback && (lim >= op);
	end
endmodule

// *** rtl/spf_formatter.sv ***
// sink capability and request object formatter, top level
// Function
// - Variable sink object: type 10b, max/min volts 50 mV, current 10 mA.
// - Battery sink object: type 01b, same voltages, power in 250 mW steps.
// - Sink voltage fields give its operating range; minimum not above maximum.
// - Answer latest source capabilities with exactly one request object.
// - Request bit 31 and bits 22..20 are always zero.
// - Object position in bits 30..28; value zero never generated.
// - Position counts offered objects from one, first after header.
// - Bit 27 GiveBack: low field is maximum when clear, minimum when set.
// - Flags: mismatch 26, USB comms 25, no suspend 24, unchunked 23.
// - Fixed/Variable request: operating and limit currents in 10 mA.
// - Battery request: operating and limit powers in 250 mW.
// - GiveBack set only when sink will cut load on GotoMin.
// - Unmet needs: still request validly and set mismatch flag.
// - Position must refer to an object of the last capabilities.
// - Operating value not above the referenced object's maximum.
// - GiveBack clear with mismatch: maximum may exceed the offer.
// - GiveBack clear without mismatch: maximum must not exceed offer.
// - GiveBack set: minimum strictly below operating value.
`timescale 1ns/100ps
`include "spf_cfg.svh"
module spf_formatter #(
	parameter int FW    = `SPF_FLD_W,
	parameter int DEPTH = `SPF_CAP_DEPTH
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               snk_build,
	input  wire logic               snk_batt,
	input  wire logic [FW-1:0]      snk_vmax,
	input  wire logic [FW-1:0]      snk_vmin,
	input  wire logic [FW-1:0]      snk_oper,
	output logic [31:0]             snk_pdo,
	output logic                    snk_pdo_valid,
	output logic                    snk_pdo_err,
	input  wire logic               caps_start,
	input  wire logic               caps_wr,
	input  wire logic [31:0]        caps_data,
	output logic [2:0]              caps_count,
	input  wire logic               req_go,
	input  wire logic [2:0]         req_pos,
	input  wire logic               req_giveback,
	input  wire logic               req_goto_min_ok,
	input  wire logic               req_unmet,
	input  wire logic               req_usb_comm,
	input  wire logic               req_no_suspend,
	input  wire logic               req_unchunked,
	input  wire logic [FW-1:0]      req_oper,
	input  wire logic [FW-1:0]      req_limit,
	output logic [31:0]             rdo,
	output logic                    rdo_valid,
	output logic                    rdo_reject,
	output logic [`SPF_ERR_W-1:0]   rdo_err,
	output logic                    rdo_batt,
	output logic                    busy
);
	////////////////////////////////////////////////////////////////////////////
	spf_cap_if cap_if ();

	spf_cap_mem #(.DEPTH(DEPTH)) u_mem (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bus     (cap_if.mem)
	);

	spf_pkg::spf_state_t state;
	spf_pkg::spf_state_t next_state;
	logic [2:0]          r_pos;
	logic                r_gb;
	logic                r_unmet;
	logic                r_usb;
	logic                r_nosusp;
	logic                r_unchk;
	logic [FW-1:0]       r_op;
	logic [FW-1:0]       r_lim;
	logic [2:0]          next_r_pos;
	logic                next_r_gb;
	logic                next_r_unmet;
	logic                next_r_usb;
	logic                next_r_nosusp;
	logic                next_r_unchk;
	logic [FW-1:0]       next_r_op;
	logic [FW-1:0]       next_r_lim;
	logic [2:0]          next_caps_count;
	logic [31:0]         next_snk_pdo;
	logic                next_snk_pdo_valid;
	logic                next_snk_pdo_err;
	logic [31:0]         next_rdo;
	logic                next_rdo_valid;
	logic                next_rdo_reject;
	logic [`SPF_ERR_W-1:0] next_rdo_err;
	logic                next_rdo_batt;
	logic                next_busy;
	logic                c_batt;
	logic                c_type_bad;
	logic                c_op_over;
	logic                c_lim_over;
	logic                c_gb_bad;
	logic                mism;

	spf_rdo_check #(.FW(FW)) u_chk (
		.pdo      (cap_if.rd_data),
		.op       (r_op),
		.lim      (r_lim),
		.giveback (r_gb),
		.is_batt  (c_batt),
		.type_bad (c_type_bad),
		.op_over  (c_op_over),
		.lim_over (c_lim_over),
		.gb_bad   (c_gb_bad)
	);

	////////////////////////////////////////////////////////////////////////////
	// capability store access
	assign cap_if.wr_en   = caps_wr && (caps_start || (caps_count < 3'(DEPTH)));
	assign cap_if.wr_addr = caps_start ? 3'h0 : caps_count;
	assign cap_if.wr_data = caps_data;
	assign cap_if.rd_en   = (state == spf_pkg::SPF_READ);
	assign cap_if.rd_addr = r_pos - 3'h1;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state         = state;
		next_r_pos         = r_pos;
		next_r_gb          = r_gb;
		next_r_unmet       = r_unmet;
		next_r_usb         = r_usb;
		next_r_nosusp      = r_nosusp;
		next_r_unchk       = r_unchk;
		next_r_op          = r_op;
		next_r_lim         = r_lim;
		next_caps_count    = caps_count;
		next_snk_pdo       = snk_pdo;
		next_snk_pdo_valid = 1'b0;
		next_snk_pdo_err   = snk_pdo_err;
		next_rdo           = rdo;
		next_rdo_valid     = 1'b0;
		next_rdo_reject    = 1'b0;
		next_rdo_err       = rdo_err;
		next_rdo_batt      = rdo_batt;
		mism               = 1'b0;

		// new capabilities replace the old ones; a full store drops extras
		if (caps_start) begin
			next_caps_count = caps_wr ? 3'h1 : 3'h0;
		end else if (cap_if.wr_en) begin
			next_caps_count = caps_count + 3'h1;
		end

		if (snk_build) begin
			next_snk_pdo = 32'h00000000;
			next_snk_pdo[`SPF_TYPE_LSB +: 2] = snk_batt ? `SPF_TYPE_BATT : `SPF_TYPE_VAR;
			next_snk_pdo[`SPF_VMAX_LSB +: FW] = snk_vmax;
			next_snk_pdo[`SPF_VMIN_LSB +: FW] = snk_vmin;
			next_snk_pdo[`SPF_LIM_LSB +: FW] = snk_oper;
			next_snk_pdo_err   = (snk_vmin > snk_vmax);
			next_snk_pdo_valid = (snk_vmin <= snk_vmax);
		end

		case (state)
			spf_pkg::SPF_IDLE: begin
				if (req_go) begin
					next_r_pos    = req_pos;
					next_r_gb     = req_giveback && req_goto_min_ok;
					next_r_unmet  = req_unmet;
					next_r_usb    = req_usb_comm;
					next_r_nosusp = req_no_suspend;
					next_r_unchk  = req_unchunked;
					next_r_op     = req_oper;
					next_r_lim    = req_limit;
					if (req_pos == `SPF_POS_RESV || req_pos > caps_count) begin
						next_rdo_reject = 1'b1;
						next_rdo_err    = '0;
						next_rdo_err[`SPF_ERR_POS] = 1'b1;
					end else begin
						next_state = spf_pkg::SPF_READ;
					end
				end
			end
			spf_pkg::SPF_READ: begin
				next_state = spf_pkg::SPF_CHECK;
			end
			spf_pkg::SPF_CHECK: begin
				next_state = spf_pkg::SPF_IDLE;
				next_rdo_err = '0;
				next_rdo_err[`SPF_ERR_OP]   = c_op_over;
				next_rdo_err[`SPF_ERR_GB]   = c_gb_bad;
				next_rdo_err[`SPF_ERR_TYPE] = c_type_bad;
				mism = r_unmet || c_lim_over;
				if (c_op_over || c_gb_bad || c_type_bad) begin
					next_rdo_reject = 1'b1;
				end else begin
					next_rdo_valid = 1'b1;
					next_rdo_batt  = c_batt;
					next_rdo = 32'h00000000;
					next_rdo[`SPF_POS_LSB +: 3] = r_pos;
					next_rdo[`SPF_GB_BIT] = r_gb;
					next_rdo[`SPF_MM_BIT]     = mism;
					next_rdo[`SPF_USB_BIT]    = r_usb;
					next_rdo[`SPF_NOSUSP_BIT] = r_nosusp;
					next_rdo[`SPF_UNCHK_BIT]  = r_unchk;
					next_rdo[`SPF_OP_LSB +: FW]  = r_op;
					next_rdo[`SPF_LIM_LSB +: FW] = r_lim;
				end
			end
			default: begin
				next_state = spf_pkg::SPF_IDLE;
			end
		endcase
		next_busy = (next_state != spf_pkg::SPF_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state         <= spf_pkg::SPF_IDLE;
			r_pos         <= 3'h0;
			r_gb          <= 1'b0;
			r_unmet       <= 1'b0;
			r_usb         <= 1'b0;
			r_nosusp      <= 1'b0;
			r_unchk       <= 1'b0;
			r_op          <= '0;
			r_lim         <= '0;
			caps_count    <= 3'h0;
			snk_pdo       <= 32'h00000000;
			snk_pdo_valid <= 1'b0;
			snk_pdo_err   <= 1'b0;
			rdo           <= 32'h00000000;
			rdo_valid     <= 1'b0;
			rdo_reject    <= 1'b0;
			rdo_err       <= '0;
			rdo_batt      <= 1'b0;
			busy          <= 1'b0;
		end else begin
			state         <= next_state;
			r_pos         <= next_r_pos;
			r_gb          <= next_r_gb;
			r_unmet       <= next_r_unmet;
			r_usb         <= next_r_usb;
			r_nosusp      <= next_r_nosusp;
			r_unchk       <= next_r_unchk;
			r_op          <= next_r_op;
			r_lim         <= next_r_lim;
			caps_count    <= next_caps_count;
			snk_pdo       <= next_snk_pdo;
			snk_pdo_valid <= next_snk_pdo_valid;
			snk_pdo_err   <= next_snk_pdo_err;
			rdo           <= next_rdo;
			rdo_valid     <= next_rdo_valid;
			rdo_reject    <= next_rdo_reject;
			rdo_err       <= next_rdo_err;
			rdo_batt      <= next_rdo_batt;
			busy          <= next_busy;
		end
	end
endmodule

// *** dv/spf_fmt_assertions.sv ***
// request formatter port checks
`timescale 1ns/100ps
module spf_fmt_assertions (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        req_go,
	input wire logic [2:0]  req_pos,
	input wire logic        req_goto_min_ok,
	input wire logic        req_unmet,
	input wire logic        busy,
	input wire logic [31:0] rdo,
	input wire logic        rdo_valid,
	input wire logic        rdo_reject,
	input wire logic [3:0]  rdo_err
);
	////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// requests while busy are dropped, so only idle ones count
	sequence take_s;
		req_go && !busy;
	endsequence
	sequence acc_s(c);
		take_s ##0 c ##3 rdo_valid;
	endsequence
	one_answer_a: assert property (take_s |-> ##[1:3] (rdo_valid ^ rdo_reject))
		else $error("request not answered once");
	rsvd_zero_a: assert property (rdo_valid |-> !rdo[31] && rdo[22:20] == 3'h0)
		else $error("reserved request bits set");
	pos_nonzero_a: assert property (rdo_valid |-> rdo[30:28] != 3'h0)
		else $error("request position zero");
	pos_bad_a: assert property (take_s ##0 req_pos == 3'h0 |=> rdo_reject && rdo_err[0])
		else $error("zero position not refused");
	gb_min_a: assert property (rdo_valid && rdo[27] |-> rdo[9:0] < rdo[19:10])
		else $error("minimum not below operating");
	gb_cause_a: assert property (acc_s(!req_goto_min_ok) |-> !rdo[27])
		else $error("giveback without load cut");
	unmet_mm_a: assert property (acc_s(req_unmet) |-> rdo[26])
		else $error("mismatch flag missing");
	rdo_hold_a: assert property (rdo_reject |-> $stable(rdo))
		else $error("refused request changed object");
endmodule

// *** dv/spf_src_model.sv ***
// source side: offers capabilities and judges each request
`timescale 1ns/100ps
module spf_src_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        offer,
	input  wire logic [31:0] rdo,
	input  wire logic        rdo_valid,
	output logic             caps_start,
	output logic             caps_wr,
	output logic [31:0]      caps_data,
	output logic [7:0]       bad
);
	////////////////////////////////
	// slot zero unused, fixed 5V first
	// last slot carries the unused type code, so the receiver must refuse it
	logic [31:0] offr [5] = '{32'h0, 32'h0001_9096, 32'h8641_912C, 32'h4641_9064,
		32'hC000_0064};
	logic [2:0]  idx;
	logic [9:0]  cap;
	// offer only when idle: a second pulse mid-message is not supported
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			idx <= 3'h0;
		else if (offer || idx != 3'h0)
			idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
	end
	assign caps_start = idx == 3'h1;
	assign caps_wr = idx != 3'h0;
	assign caps_data = offr[idx];
	assign cap = offr[rdo[29:28]][9:0];
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			bad <= 8'h0;
		else if (rdo_valid && (rdo[31] || rdo[30] || rdo[29:28] == 2'h0 || rdo[22:20] != 3'h0
				|| rdo[19:10] > cap || (rdo[27] ? rdo[9:0] >= rdo[19:10] : !rdo[26] && rdo[9:0] > cap)))
			bad <= bad + 8'h1;
	end
endmodule

// *** dv/spf_tb.sv ***
// self-checking bench for the sink object formatter
`timescale 1ns/100ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst_n, snk_build, snk_batt, caps_start, caps_wr, offer, req_go, busy;
	logic        req_giveback, req_goto_min_ok, req_unmet, req_usb_comm, req_no_suspend;
	logic        req_unchunked, snk_pdo_valid, snk_pdo_err, rdo_valid, rdo_reject, rdo_batt;
	logic [9:0]  snk_vmax, snk_vmin, snk_oper, req_oper, req_limit;
	logic [31:0] snk_pdo, caps_data, rdo, w;
	logic [2:0]  caps_count, req_pos;
	logic [3:0]  rdo_err;
	logic [7:0]  bad;
	int          errors = 0;
	int          check_count = 0;
	////////////////////////////////
	spf_formatter i_spf_formatter (.*);
	spf_src_model i_spf_src_model (.*);
	always #5 clk_sys = ~clk_sys;
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic sc_sink(input logic b, input logic [9:0] mx, mn, op);
		{snk_batt, snk_vmax, snk_vmin, snk_oper, snk_build} = {b, mx, mn, op, 1'h1};
		@(posedge clk_sys) snk_build <= 1'b0;
		#1 chk("snk_pdo", snk_pdo, {b ? 2'h1 : 2'h2, mx, mn, op});
		chk("snk_pdo_valid", snk_pdo_valid, mn <= mx);
		chk("snk_pdo_err", snk_pdo_err, mn > mx);
	endtask
	// gm: expected giveback and mismatch bits of an accepted request
	task automatic rq(input logic [2:0] p, input logic [5:0] f, input logic [9:0] o, l,
			input int lat, input logic [3:0] ee, input logic [1:0] gm);
		{req_giveback, req_goto_min_ok, req_unmet, req_usb_comm, req_no_suspend, req_unchunked} = f;
		{req_pos, req_oper, req_limit, req_go} = {p, o, l, 1'h1};
		if (ee == 4'h0)
			w = {1'h0, p, gm, f[2:0], 3'h0, o, l};
		@(posedge clk_sys) req_go <= 1'b0;
		// busy stands from the taking edge until the answer
		repeat (lat - 1) begin
			#1 chk("busy", busy, 1'h1);
			@(posedge clk_sys);
		end
		#1 chk("answer", {rdo_valid, rdo_reject}, ee == 4'h0 ? 2'h2 : 2'h1);
		chk("rdo", rdo, w);
		chk("rdo_err", rdo_err, ee);
		chk("busy", busy, 1'h0);
	endtask
	task automatic sc_offer;
		offer = 1'b1;
		@(posedge clk_sys) offer <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 chk("caps_count", caps_count, 3'h4);
	endtask
	task automatic sc_accept;
		rq(3'h1, 6'h04, 10'h064, 10'h096, 3, 4'h0, 2'h0);
		chk("rdo_batt", rdo_batt, 1'h0);
		rq(3'h3, 6'h32, 10'h050, 10'h014, 3, 4'h0, 2'h2);
		chk("rdo_batt", rdo_batt, 1'h1);
		rq(3'h2, 6'h20, 10'h0C8, 10'h0FA, 3, 4'h0, 2'h0);
		rq(3'h1, 6'h00, 10'h064, 10'h097, 3, 4'h0, 2'h1);
		rq(3'h2, 6'h09, 10'h0C8, 10'h190, 3, 4'h0, 2'h1);
	endtask
	task automatic sc_refuse;
		rq(3'h0, 6'h00, 10'h005, 10'h005, 1, 4'h1, 2'h0);
		rq(3'h5, 6'h00, 10'h005, 10'h005, 1, 4'h1, 2'h0);
		rq(3'h2, 6'h00, 10'h12D, 10'h005, 3, 4'h2, 2'h0);
		rq(3'h1, 6'h30, 10'h032, 10'h032, 3, 4'h4, 2'h0);
		rq(3'h4, 6'h00, 10'h005, 10'h005, 3, 4'h8, 2'h0);
		chk("bad", bad, 8'h0);
	endtask
	task final_report;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		#5000;
		errors++;
		final_report();
	end
	initial begin
		{snk_build, snk_batt, offer, req_go, rst_n} = 5'h0;
		{req_giveback, req_goto_min_ok, req_unmet, req_usb_comm, req_no_suspend} = 5'h0;
		{req_unchunked, snk_vmax, snk_vmin, snk_oper, req_oper, req_limit, req_pos} = 54'h0;
		w = 32'h0;
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk("caps_count", caps_count, 3'h0);
		sc_sink(1'h0, 10'h064, 10'h03C, 10'h096);
		sc_sink(1'h1, 10'h054, 10'h038, 10'h028);
		sc_sink(1'h0, 10'h032, 10'h03C, 10'h00A);
		sc_offer();
		sc_accept();
		sc_refuse();
		final_report();
	end
endmodule
bind spf_formatter spf_fmt_assertions i_spf_fmt_assertions (.*);
